// [src/swsa_defs.svh]
/*
 Constants of the single-wire command and search accelerator block.
 Assumes a 20 MHz system clock; all line timing is in 1 us base ticks.
*/
`ifndef SWSA_DEFS_SVH
`define SWSA_DEFS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define SWSA_CLK_HZ 20000000
`define SWSA_BASE_HZ 1000000
`define SWSA_DIV_CYCLES (`SWSA_CLK_HZ / `SWSA_BASE_HZ)

// ----------------------------------------
// Internal register addresses
// ----------------------------------------
`define SWSA_A_CMD 3'h0
`define SWSA_A_BUF 3'h1
`define SWSA_A_FLAG 3'h2
`define SWSA_A_CTRL 3'h5
`define SWSA_ADDR_RST 3'h7

// ----------------------------------------
// Bit positions
// ----------------------------------------
`define SWSA_CMD_RST 0
`define SWSA_CMD_SRA 1
`define SWSA_CMD_FOW 2
`define SWSA_CMD_IN 3
`define SWSA_CTRL_ENFOW 2
`define SWSA_FLG_PD 0
`define SWSA_FLG_PDR 1
`define SWSA_FLG_TBE 2
`define SWSA_FLG_RBF 4

// ----------------------------------------
// Line timing in microseconds and bit counts
// ----------------------------------------
`define SWSA_RST_LOW_US 10'd480
`define SWSA_RST_SAMP_US 10'd550
`define SWSA_RST_END_US 10'd960
`define SWSA_W1_LOW_US 10'd5
`define SWSA_W0_LOW_US 10'd60
`define SWSA_SLOT_SAMP_US 10'd15
`define SWSA_SLOT_END_US 10'd70
`define SWSA_SEARCH_BITS 4'd4
`define SWSA_NORM_BITS 4'd8

`endif

// [src/swsa_pkg.sv]
/*
 Types of the single-wire command and search accelerator block.
 Assumes swsa_defs.svh is included alongside where constants are needed.
*/
package swsa_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_SLOT} swsa_state_t;
endpackage : swsa_pkg

// [src/swsa_master.sv]
/*
 Command logic and search accelerator of a single-wire bus master.
 Assumes a CPU with an address/data register pair and an open-drain line.
*/
`timescale 1ns/1ns
`include "swsa_defs.svh"

module swsa_master
	import swsa_pkg::*;
#(
	parameter int DATA_W = 8
)(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic reg_sel_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [DATA_W-1:0] wdata_i,
	output logic [DATA_W-1:0] rdata_o,
	input wire logic line_input_level_i,
	output logic line_o,
	output logic line_oe_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Returns {write bit, ID bit, discrepancy flag, error}
	function automatic logic [3:0] decide(input logic a, input logic b, input logic r, input logic err);
		logic [3:0] res;
		res = 4'h0;
		if (err)
			res = 4'he;
		else if (a != b)
			res = {a, a, 1'b0, 1'b0};
		else if (!a)
			res = {r, r, 1'b1, 1'b0};
		else
			res = 4'hf;
		return res;
	endfunction : decide

	// ----------------------------------------
	// State
	// ----------------------------------------
	swsa_state_t state_reg, state_next;
	logic [4:0] div_reg, div_next;
	logic [9:0] us_reg, us_next;
	logic [1:0] phase_reg, phase_next;
	logic [2:0] bit_reg, bit_next;
	logic [DATA_W-1:0] txs_reg, txs_next, rxs_reg, rxs_next, txb_reg, txb_next;
	logic txf_reg, txf_next, rda_reg, rda_next, samp_reg, samp_next, sbit_reg, sbit_next;
	logic err_reg, err_next, rst_reg, rst_next, sra_reg, sra_next, fow_reg, fow_next;
	logic enfow_reg, enfow_next, pd_reg, pd_next, pdr_reg, pdr_next;
	logic [2:0] addr_reg, addr_next;
	logic [DATA_W-1:0] fifo_mem [2];
	logic [DATA_W-1:0] rdata_next;
	logic wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [1:0] cnt_reg, cnt_next;
	logic tick, drive, push_valid, push_ready, pop_valid, pop_ready, slot_end;
	logic [3:0] dec;
	logic [DATA_W-1:0] flags;

	assign tick = (div_reg == 5'(`SWSA_DIV_CYCLES - 1));
	assign slot_end = tick && (us_reg == `SWSA_SLOT_END_US - 10'd1);
	assign push_ready = (cnt_reg != 2'd2);
	assign pop_valid = (cnt_reg != 2'd0);
	assign pop_ready = rd_en_i && reg_sel_i && (addr_reg == `SWSA_A_BUF);
	assign dec = decide(rda_reg, samp_reg, txs_reg[{bit_reg[1:0], 1'b1}], err_reg);
	assign flags = DATA_W'({pop_valid, 1'b0, !txf_reg, pdr_reg, pd_reg});

	always_comb
	begin
		drive = 1'b0;
		if (state_reg == ST_RESET)
			drive = (us_reg < `SWSA_RST_LOW_US);
		else if (state_reg == ST_SLOT)
			drive = (us_reg < (sbit_reg ? `SWSA_W1_LOW_US : `SWSA_W0_LOW_US));
	end

	assign line_o = 1'b0;
	assign line_oe_o = drive || (fow_reg && enfow_reg);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		state_next = state_reg;
		div_next = tick ? 5'd0 : div_reg + 5'd1;
		us_next = us_reg;
		phase_next = phase_reg;
		bit_next = bit_reg;
		txs_next = txs_reg;
		rxs_next = rxs_reg;
		txb_next = txb_reg;
		txf_next = txf_reg;
		rda_next = rda_reg;
		samp_next = samp_reg;
		sbit_next = sbit_reg;
		err_next = err_reg;
		rst_next = rst_reg;
		sra_next = sra_reg;
		fow_next = fow_reg;
		enfow_next = enfow_reg;
		pd_next = pd_reg;
		pdr_next = pdr_reg;
		addr_next = addr_reg;
		wptr_next = wptr_reg;
		rptr_next = rptr_reg;
		push_valid = 1'b0;
		rdata_next = rdata_o;

		// CPU side
		if (rd_en_i)
		begin
			rdata_next = '0;
			if (!reg_sel_i)
				rdata_next = DATA_W'(addr_reg);
			else
				unique case (addr_reg)
					`SWSA_A_CMD: rdata_next = DATA_W'({line_input_level_i, fow_reg, sra_reg, rst_reg});
					`SWSA_A_BUF: rdata_next = fifo_mem[rptr_reg];
					`SWSA_A_FLAG: rdata_next = flags;
					`SWSA_A_CTRL: rdata_next = DATA_W'({enfow_reg, 2'b00});
					default: rdata_next = '0;
				endcase
			if (reg_sel_i && addr_reg == `SWSA_A_FLAG)
				pd_next = 1'b0;
		end
		if (wr_en_i && !reg_sel_i)
			addr_next = wdata_i[2:0];
		if (wr_en_i && reg_sel_i)
			unique case (addr_reg)
				`SWSA_A_CMD:
				begin
					fow_next = wdata_i[`SWSA_CMD_FOW];
					if (wdata_i[`SWSA_CMD_RST])
					begin
						rst_next = 1'b1;
						sra_next = 1'b0;
					end
					else
						sra_next = wdata_i[`SWSA_CMD_SRA];
				end
				`SWSA_A_BUF:
				begin
					txb_next = wdata_i;
					txf_next = 1'b1;
				end
				`SWSA_A_CTRL: enfow_next = wdata_i[`SWSA_CTRL_ENFOW];
				default: ;
			endcase
		if (!sra_next)
			err_next = 1'b0;

		// Line engine
		if (tick && state_reg != ST_IDLE)
			us_next = us_reg + 10'd1;
		unique case (state_reg)
			ST_IDLE:
			begin
				us_next = '0;
				if (rst_reg)
					state_next = ST_RESET;
				else if (txf_reg && push_ready)
				begin
					state_next = ST_SLOT;
					txs_next = txb_reg;
					txf_next = txf_next && wr_en_i && reg_sel_i && addr_reg == `SWSA_A_BUF;
					bit_next = '0;
					phase_next = '0;
					sbit_next = sra_reg ? 1'b1 : txb_reg[0];
				end
			end
			ST_RESET:
			begin
				if (tick && us_reg == `SWSA_RST_SAMP_US)
					samp_next = line_input_level_i;
				if (tick && us_reg == `SWSA_RST_END_US - 10'd1)
				begin
					state_next = ST_IDLE;
					rst_next = 1'b0;
					pd_next = 1'b1;
					pdr_next = samp_reg;
				end
			end
			ST_SLOT:
			begin
				if (tick && us_reg == `SWSA_SLOT_SAMP_US)
					samp_next = line_input_level_i;
				if (slot_end)
				begin
					us_next = '0;
					if (!sra_reg)
					begin
						rxs_next[bit_reg] = samp_reg;
						sbit_next = txs_reg[3'(bit_reg + 3'd1)];
						if (bit_reg == 3'(`SWSA_NORM_BITS - 4'd1))
							push_valid = 1'b1;
						bit_next = bit_reg + 3'd1;
					end
					else
						unique case (phase_reg)
							2'd0:
							begin
								rda_next = samp_reg;
								phase_next = 2'd1;
							end
							2'd1:
							begin
								sbit_next = dec[3];
								rxs_next[{bit_reg[1:0], 1'b1}] = dec[2];
								rxs_next[{bit_reg[1:0], 1'b0}] = dec[1];
								err_next = err_reg || dec[0];
								phase_next = 2'd2;
							end
							default:
							begin
								phase_next = 2'd0;
								sbit_next = 1'b1;
								if (bit_reg == 3'(`SWSA_SEARCH_BITS - 4'd1))
									push_valid = 1'b1;
								bit_next = bit_reg + 3'd1;
							end
						endcase
					if (push_valid)
						state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
		if (wr_en_i && reg_sel_i && addr_reg == `SWSA_A_CMD && wdata_i[`SWSA_CMD_RST])
			rst_next = 1'b1;
		if (push_valid && push_ready)
			wptr_next = !wptr_reg;
		if (pop_ready && pop_valid)
			rptr_next = !rptr_reg;
		cnt_next = cnt_reg + 2'(push_valid && push_ready) - 2'(pop_ready && pop_valid);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (push_valid && push_ready)
			fifo_mem[wptr_reg] <= rxs_next;
		if (sys_rst_i)
		begin
			state_reg <= ST_IDLE;
			div_reg <= '0;
			us_reg <= '0;
			phase_reg <= '0;
			bit_reg <= '0;
			txs_reg <= '0;
			rxs_reg <= '0;
			txb_reg <= '0;
			txf_reg <= 1'b0;
			rda_reg <= 1'b0;
			samp_reg <= 1'b1;
			sbit_reg <= 1'b1;
			err_reg <= 1'b0;
			rst_reg <= 1'b0;
			sra_reg <= 1'b0;
			fow_reg <= 1'b0;
			enfow_reg <= 1'b0;
			pd_reg <= 1'b0;
			pdr_reg <= 1'b0;
			addr_reg <= `SWSA_ADDR_RST;
			wptr_reg <= 1'b0;
			rptr_reg <= 1'b0;
			cnt_reg <= '0;
			rdata_o <= '0;
		end
		else
		begin
			state_reg <= state_next;
			div_reg <= div_next;
			us_reg <= us_next;
			phase_reg <= phase_next;
			bit_reg <= bit_next;
			txs_reg <= txs_next;
			rxs_reg <= rxs_next;
			txb_reg <= txb_next;
			txf_reg <= txf_next;
			rda_reg <= rda_next;
			samp_reg <= samp_next;
			sbit_reg <= sbit_next;
			err_reg <= err_next;
			rst_reg <= rst_next;
			sra_reg <= sra_next;
			fow_reg <= fow_next;
			enfow_reg <= enfow_next;
			pd_reg <= pd_next;
			pdr_reg <= pdr_next;
			addr_reg <= addr_next;
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			cnt_reg <= cnt_next;
			rdata_o <= rdata_next;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence cmd_read_s;
		rd_en_i && reg_sel_i && addr_reg == `SWSA_A_CMD;
	endsequence
	sequence rst_write_s;
		wr_en_i && reg_sel_i && addr_reg == `SWSA_A_CMD && wdata_i[`SWSA_CMD_RST];
	endsequence

	a_cmd_read_value: assert property (cmd_read_s |=> rdata_o[7:4] == 4'h0 && rdata_o[3] == $past(line_input_level_i))
		else $error("command read value wrong");
	a_force_low_drive: assert property (fow_reg && enfow_reg |-> line_oe_o)
		else $error("forced low not driven");
	a_force_idle_off: assert property (state_reg == ST_IDLE && !enfow_reg |-> !line_oe_o)
		else $error("line driven while idle");
	a_reset_clears_sra: assert property (rst_write_s |=> rst_reg && !sra_reg)
		else $error("reset write did not clear accelerator mode");
	a_reset_done_flag: assert property ($fell(rst_reg) |-> pd_reg && state_reg == ST_IDLE)
		else $error("presence done not set at reset end");
	a_reset_low_span: assert property ($rose(state_reg == ST_RESET) |-> line_oe_o [*8])
		else $error("reset low not held");
	a_accel_push_len: assert property (push_valid && sra_reg |-> bit_reg == 3'd3 && phase_reg == 2'd2)
		else $error("accelerator byte length wrong");
	a_err_write_one: assert property (slot_end && sra_reg && phase_reg == 2'd1 && (err_reg || (rda_reg && samp_reg))
		|=> sbit_reg && err_reg)
		else $error("error bit not written as one");
	a_rx_push_full: assert property (push_valid && push_ready |=> pop_valid)
		else $error("receive buffer full not set");

endmodule : swsa_master

// [bench/swsa_slave_model.sv]
/*
 Behavioural slave on the shared line: presence pulse, ID bits in search slots.
 Assumes a pull-up on the line and state changes at the falling clock edge.
*/
`timescale 1ns/1ns

module swsa_slave_model #(
	parameter logic [63:0] ROM_ID = 64'h0
)(
	input wire logic clk_i,
	input wire logic line_i,
	input wire logic en_i,
	output logic pull_o
);
	int n = 0;
	int t = 0;
	int lowc = 0;
	int pr = 3000;
	bit act = 1'b0;
	logic prev = 1'b1;
	int ph;
	int b;
	logic sb;

	always_comb
	begin
		ph = (n - 8) % 3;
		b = (n >= 8) ? ((n - 8) / 3) % 64 : 0;
		sb = (ph == 0) ? ROM_ID[b] : ~ROM_ID[b];
	end

	assign pull_o = en_i && ((pr >= 400 && pr < 2400) || (act && n >= 8 && ph < 2 && t < 600 && !sb));

	always @(negedge clk_i)
	begin
		if (pr < 3000)
			pr = pr + 1;
		if (!prev && line_i && lowc > 8000)
		begin
			n = -1;
			act = 1'b1;
			pr = 0;
		end
		lowc = line_i ? 0 : lowc + 1;
		if (prev && !line_i && !pull_o)
		begin
			n = n + 1;
			t = 0;
		end
		else
			t = t + 1;
		if (act && n >= 8 && ph == 2 && t == 600 && line_i !== ROM_ID[b])
			act = 1'b0;
		prev = line_i;
	end
endmodule : swsa_slave_model

// [bench/tb.sv]
/*
 Self-checking bench of the single-wire master with two search slaves.
 Assumes a pull-up on the line and the slave model beside the master.
*/
`timescale 1ns/1ns

module tb;
	localparam logic [63:0] ID_A = 64'ha;
	localparam logic [63:0] ID_B = 64'hc;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic reg_sel_i = 1'b0;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o;
	logic line_o;
	logic line_oe_o;
	logic en = 1'b0;
	logic pull_a;
	logic pull_b;
	wire line = !(line_oe_o || pull_a || pull_b);
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	int bn = 0;
	bit act_a;
	bit act_b;
	bit err;
	logic [7:0] v;
	logic [7:0] tx;
	logic [7:0] exp_q[$];

	swsa_master swsa_master_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_sel_i(reg_sel_i), .wr_en_i(wr_en_i),
		.rd_en_i(rd_en_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .line_input_level_i(line), .line_o(line_o),
		.line_oe_o(line_oe_o));
	swsa_slave_model #(.ROM_ID(ID_A)) slave_a_i (.clk_i(clk_i), .line_i(line), .en_i(en), .pull_o(pull_a));
	swsa_slave_model #(.ROM_ID(ID_B)) slave_b_i (.clk_i(clk_i), .line_i(line), .en_i(en), .pull_o(pull_b));

	// ----------------------------------------
	// Reference search model
	// ----------------------------------------
	task automatic model_byte(input logic [7:0] d, input bit off);
		logic [7:0] rx;
		bit r1;
		bit r2;
		bit w;
		rx = 8'h00;
		for (int k = 0; k < 4; k++)
		begin
			r1 = !((act_a && !ID_A[bn]) || (act_b && !ID_B[bn]));
			r2 = !((act_a && ID_A[bn]) || (act_b && ID_B[bn]));
			err = err || off || (r1 && r2);
			w = err ? 1'b1 : (r1 != r2) ? r1 : d[2*k+1];
			rx[2*k+1] = w;
			rx[2*k] = err || (r1 == r2);
			act_a = act_a && (ID_A[bn] == w);
			act_b = act_b && (ID_B[bn] == w);
			bn++;
		end
		exp_q.push_back(rx);
	endtask : model_byte

	// ----------------------------------------
	// Register access and checks
	// ----------------------------------------
	task automatic wr(input logic sel, input logic [7:0] d);
		@(negedge clk_i);
		reg_sel_i = sel;
		wdata_i = d;
		wr_en_i = 1'b1;
		@(negedge clk_i);
		wr_en_i = 1'b0;
	endtask : wr

	task automatic rd(input logic sel, output logic [7:0] d);
		@(negedge clk_i);
		reg_sel_i = sel;
		rd_en_i = 1'b1;
		@(negedge clk_i);
		rd_en_i = 1'b0;
		d = rdata_o;
	endtask : rd

	task automatic regw(input logic [2:0] a, input logic [7:0] d);
		wr(1'b0, {5'h00, a});
		wr(1'b1, d);
	endtask : regw

	task automatic regr(input logic [2:0] a, output logic [7:0] d);
		wr(1'b0, {5'h00, a});
		rd(1'b1, d);
	endtask : regr

	task automatic poll(input logic [2:0] a, input int bi, input logic bv);
		regr(a, v);
		for (int i = 0; i < 40000 && v[bi] !== bv; i++)
			rd(1'b1, v);
	endtask : poll

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_line(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: drive %h expected %h", $time, got, exp);
		end
	endtask : chk_line

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	// ----------------------------------------
	// Clock, timeout and sequence
	// ----------------------------------------
	initial
	begin
		forever #25 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			err_total++;
			print_verdict();
		end
	end

	initial
	begin
		v = $urandom(39173);
		repeat (16) @(negedge clk_i);
		sys_rst_i = 1'b0;
		regr(3'h0, v);
		chk_reg(v, 8'h08);
		regr(3'h6, v);
		chk_reg(v, 8'h00);
		regw(3'h5, 8'h00);
		regw(3'h0, 8'h04);
		chk_line(line_oe_o, 1'b0);
		regr(3'h0, v);
		chk_reg(v, 8'h0c);
		regw(3'h5, 8'h04);
		chk_line(line_oe_o, 1'b1);
		chk_line(line_o, 1'b0);
		regr(3'h0, v);
		chk_reg(v, 8'h04);
		regw(3'h5, 8'h00);
		regw(3'h0, 8'h00);
		$display("Test force low done");
		for (int p = 0; p < 2; p++)
		begin
			en = p[0];
			regw(3'h0, 8'h02);
			regw(3'h0, 8'h01);
			regr(3'h0, v);
			chk_reg(v & 8'hf7, 8'h01);
			chk_line(line_oe_o, 1'b1);
			poll(3'h0, 0, 1'b0);
			chk_reg(v, 8'h08);
			regr(3'h2, v);
			chk_reg(v & 8'h03, {6'h00, ~en, 1'b1});
			$display("Test bus reset %0d done", p);
		end
		regw(3'h1, 8'hf0);
		poll(3'h2, 4, 1'b1);
		chk_reg(v & 8'h10, 8'h10);
		regr(3'h1, v);
		chk_reg(v, 8'hf0);
		$display("Test search command done");
		regw(3'h0, 8'h02);
		regr(3'h0, v);
		chk_reg(v & 8'hf7, 8'h02);
		act_a = 1'b1;
		act_b = 1'b1;
		err = 1'b0;
		for (int k = 0; k < 2; k++)
		begin
			tx = 8'($urandom);
			model_byte(tx, k == 1);
			en = (k == 0);
			regw(3'h1, tx);
			if (k == 1)
			begin
				repeat (4200) @(negedge clk_i);
				en = 1'b1;
			end
			poll(3'h2, 4, 1'b1);
			regr(3'h1, v);
			chk_reg(v, exp_q.pop_front());
			$display("Test search byte %0d done", k);
		end
		regw(3'h0, 8'h00);
		regr(3'h0, v);
		chk_reg(v, 8'h08);
		print_verdict();
	end
endmodule : tb
